// >>> design/fso_ctrl_pkg.sv
package fso_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int INIT_DELAY_NS = 150_000;
  localparam int INIT_CYCLES =
    (INIT_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [11:0] INIT_LAST = 12'(INIT_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Register byte offsets and values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_THRESH = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_RANGE = 8'h0c;
  localparam logic [7:0] ADDR_TRIM = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Mode select codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_SAFE_ZERO = 3'h0;
  localparam logic [2:0] MODE_OTP_LOAD = 3'h1;
  localparam logic [2:0] MODE_FSO_ZERO_RO = 3'h2;
  localparam logic [2:0] MODE_FSO_ZERO_RW = 3'h3;
  localparam logic [2:0] MODE_FSO_OTP_RW = 3'h5;
  localparam logic [2:0] MODE_SA_RO = 3'h6;

  typedef enum logic [2:0] {ST_RESET, ST_INIT, ST_NORMAL, ST_FSO, ST_SA}
    op_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [1:0][7:0] threshold_upper;
    logic [1:0][1:0] sense_range_low;
    logic [1:0][4:0] off_time;
    logic [1:0] channel_enable;
    logic [2:0] failsafe_mode_select;
    logic [1:0] thermal_auto_recover_enable;
    logic [1:0] overcurrent_comparator_level;
  } otp_image_t;

  typedef struct packed {
    logic [1:0][8:0] current_threshold_code;
    logic [1:0][2:0] sense_range_select;
    logic [1:0][4:0] off_time;
    logic [1:0] channel_enable;
    logic [2:0] failsafe_mode_select;
    logic [1:0] overcurrent_comparator_level;
    logic [1:0] thermal_auto_recover_enable;
    logic [1:0][6:0] sense_range_value;
    logic [1:0][6:0] sense_trim_value;
  } ctrl_regs_t;

  // Codes whose reset pin acts as a plain reset.
  function automatic logic is_reset_code(input logic [2:0] m);
    return (m == MODE_SAFE_ZERO) || (m == MODE_OTP_LOAD) || (m >= MODE_SA_RO);
  endfunction : is_reset_code

  // Codes that block serial writes and clear-on-read.
  function automatic logic is_write_locked(input logic [2:0] m);
    return (m[0] == 1'b0) && (m != MODE_SAFE_ZERO);
  endfunction : is_write_locked

  function automatic logic [31:0] wb_merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~mask) | (dat & mask);
  endfunction : wb_merge

  // Places a merged bus word into the register that it addresses.
  function automatic ctrl_regs_t reg_write(input ctrl_regs_t c,
    input logic [7:0] adr, input logic [31:0] w);
    ctrl_regs_t r;
    r = c;
    case (adr)
      ADDR_THRESH:
      begin
        r.current_threshold_code[0] = w[8:0];
        r.current_threshold_code[1] = w[24:16];
      end
      ADDR_TIMING:
      begin
        r.sense_range_select[0] = w[2:0];
        r.sense_range_select[1] = w[6:4];
        r.off_time[0] = w[12:8];
        r.off_time[1] = w[20:16];
      end
      ADDR_CONTROL:
      begin
        r.channel_enable = w[1:0];
        r.failsafe_mode_select = w[4:2];
        r.overcurrent_comparator_level = w[6:5];
        r.thermal_auto_recover_enable = w[8:7];
      end
      ADDR_RANGE:
      begin
        r.sense_range_value[0] = w[6:0];
        r.sense_range_value[1] = w[14:8];
      end
      ADDR_TRIM:
      begin
        r.sense_trim_value[0] = w[6:0];
        r.sense_trim_value[1] = w[14:8];
      end
      default:
        r = c;
    endcase
    return r;
  endfunction : reg_write

  function automatic ctrl_regs_t otp_preload(input ctrl_regs_t c,
    input otp_image_t o);
    ctrl_regs_t r;
    r = c;
    for (int i = 0; i < 2; i++)
    begin
      r.current_threshold_code[i][8:1] = o.threshold_upper[i];
      r.sense_range_select[i][1:0] = o.sense_range_low[i];
      r.off_time[i] = o.off_time[i];
      r.sense_trim_value[i] = c.sense_range_value[i];
    end
    r.channel_enable = o.channel_enable;
    r.failsafe_mode_select = o.failsafe_mode_select;
    r.thermal_auto_recover_enable = o.thermal_auto_recover_enable;
    r.overcurrent_comparator_level = o.overcurrent_comparator_level;
    return r;
  endfunction : otp_preload

endpackage : fso_ctrl_pkg

// >>> design/failsafe_mode_controller.sv
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps

module failsafe_mode_controller (
  input wire logic clk,
  input wire logic rst,
  input wire fso_ctrl_pkg::wb_req_t wb_req,
  output fso_ctrl_pkg::wb_rsp_t wb_rsp,
  input wire logic reset_input_low,
  input wire logic [1:0] led_control_inputs,
  input wire logic otp_lock_bit,
  input wire fso_ctrl_pkg::otp_image_t otp_image,
  input wire logic serial_frame_error,
  output fso_ctrl_pkg::ctrl_regs_t ctrl_out,
  output logic [1:0] buck_enable,
  output logic digital_reset,
  output fso_ctrl_pkg::op_state_t op_state,
  output logic failsafe_entered_flag,
  output logic serial_error_flag,
  output logic stand_alone_mode,
  output logic serial_write_blocked
);
  import fso_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pin_sync_reg;
  logic pin_lvl_reg;
  logic [2:0][1:0] led_sync_reg;
  logic [1:0] led_lvl_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_sync_reg <= 3'h0;
      led_sync_reg <= 6'h00;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[1:0], reset_input_low};
      led_sync_reg <= {led_sync_reg[1:0], led_control_inputs};
    end
  end

  wire pin_agree = pin_sync_reg[1] == pin_sync_reg[2];
  wire pin_next = pin_agree ? pin_sync_reg[2] : pin_lvl_reg;
  wire pin_fall = pin_lvl_reg & ~pin_next;
  wire pin_rise = ~pin_lvl_reg & pin_next;
  wire [1:0] led_diff = led_sync_reg[1] ^ led_sync_reg[2];
  wire [1:0] led_next = (~led_diff & led_sync_reg[2]) |
    (led_diff & led_lvl_reg);

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  op_state_t state_reg, state_next;
  ctrl_regs_t ctrl_reg, ctrl_next, ctrl_wr;
  logic [2:0] latched_mode_reg, latched_mode_next;
  logic [11:0] init_cnt_reg, init_cnt_next;
  logic hold_en_reg, hold_en_next;
  logic fso_flag_reg, serr_flag_reg, fso_set;
  logic blocked_reg, ack_reg;
  logic [31:0] rdat_reg;
  logic [1:0] buck_en_reg;
  logic rst_out_reg, sa_reg;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire bus_req = wb_req.cyc & wb_req.stb;
  wire bus_done = bus_req & ack_reg;
  wire in_fso = state_reg == ST_FSO;
  wire in_sa = state_reg == ST_SA;
  wire blocked_w = (in_fso & is_write_locked(latched_mode_reg)) |
    (in_sa & is_write_locked(ctrl_reg.failsafe_mode_select));
  wire hit_thresh = wb_req.adr == ADDR_THRESH;
  wire hit_timing = wb_req.adr == ADDR_TIMING;
  wire hit_control = wb_req.adr == ADDR_CONTROL;
  wire hit_range = wb_req.adr == ADDR_RANGE;
  wire hit_trim = wb_req.adr == ADDR_TRIM;
  wire hit_status = wb_req.adr == ADDR_STATUS;
  wire mapped = hit_thresh | hit_timing | hit_control | hit_range |
    hit_trim | hit_status;
  wire wr_ok = bus_done & wb_req.we & ~blocked_w;
  wire valid_op = bus_done & mapped;
  wire clr_flags = bus_done & ~wb_req.we & hit_status & ~blocked_w;

  wire [31:0] thresh_word = {7'h00, ctrl_reg.current_threshold_code[1],
    7'h00, ctrl_reg.current_threshold_code[0]};
  wire [31:0] timing_word = {11'h000, ctrl_reg.off_time[1], 3'h0,
    ctrl_reg.off_time[0], 1'b0, ctrl_reg.sense_range_select[1], 1'b0,
    ctrl_reg.sense_range_select[0]};
  wire [31:0] control_word = {23'h000000,
    ctrl_reg.thermal_auto_recover_enable,
    ctrl_reg.overcurrent_comparator_level,
    ctrl_reg.failsafe_mode_select, ctrl_reg.channel_enable};
  wire [31:0] range_word = {17'h00000, ctrl_reg.sense_range_value[1], 1'b0,
    ctrl_reg.sense_range_value[0]};
  wire [31:0] trim_word = {17'h00000, ctrl_reg.sense_trim_value[1], 1'b0,
    ctrl_reg.sense_trim_value[0]};
  wire [31:0] status_word = {19'h00000, hold_en_reg, 1'b0, latched_mode_reg,
    1'b0, state_reg, 2'h0, serr_flag_reg, fso_flag_reg};
  wire [31:0] rd_word = hit_thresh ? thresh_word :
    hit_timing ? timing_word :
    hit_control ? control_word :
    hit_range ? range_word :
    hit_trim ? trim_word :
    hit_status ? status_word : RESET_WORD;

  wire [31:0] w_word = wb_merge(rd_word, wb_req.dat, wb_req.sel);
  wire exit_code = w_word[4:2] == MODE_SAFE_ZERO ||
    w_word[4:2] == MODE_OTP_LOAD;
  wire exit_allowed = latched_mode_reg == MODE_FSO_ZERO_RW ||
    latched_mode_reg == MODE_FSO_OTP_RW;
  wire exit_by_write = wr_ok & hit_control & in_fso & exit_code &
    exit_allowed;
  wire [2:0] otp_mode = otp_lock_bit ? otp_image.failsafe_mode_select :
    MODE_SAFE_ZERO;
  wire fso_code = ~is_reset_code(ctrl_reg.failsafe_mode_select);

  assign ctrl_wr = wr_ok ? reg_write(ctrl_reg, wb_req.adr, w_word) :
    ctrl_reg;

  // ----------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    ctrl_next = ctrl_wr;
    latched_mode_next = latched_mode_reg;
    init_cnt_next = 12'h000;
    hold_en_next = hold_en_reg & ~valid_op;
    fso_set = 1'b0;
    case (state_reg)
      ST_RESET:
      begin
        ctrl_next = '0;
        latched_mode_next = 3'h0;
        hold_en_next = 1'b0;
        if (pin_next)
          state_next = ST_INIT;
      end
      ST_INIT:
      begin
        ctrl_next = '0;
        init_cnt_next = init_cnt_reg + 12'h001;
        if (!pin_next)
          state_next = ST_RESET;
        else if (init_cnt_reg == INIT_LAST)
        begin
          state_next = ST_NORMAL;
          init_cnt_next = 12'h000;
          if (otp_mode == MODE_SAFE_ZERO)
            ctrl_next = '0;
          else if (otp_mode <= MODE_FSO_ZERO_RW)
          begin
            if (otp_mode != MODE_OTP_LOAD)
              ctrl_next.failsafe_mode_select = otp_mode;
            else
              ctrl_next = otp_preload('0, otp_image);
          end
          else
          begin
            ctrl_next = otp_preload('0, otp_image);
            if (otp_mode >= MODE_SA_RO)
              state_next = ST_SA;
            else
              hold_en_next = 1'b1;
          end
        end
      end
      ST_NORMAL:
      begin
        if (pin_fall && fso_code && otp_lock_bit)
        begin
          state_next = ST_FSO;
          latched_mode_next = ctrl_reg.failsafe_mode_select;
          ctrl_next = otp_preload(ctrl_reg, otp_image);
          fso_set = 1'b1;
        end
        else if (!pin_next && (!fso_code || !otp_lock_bit))
          state_next = ST_RESET;
      end
      ST_FSO:
      begin
        if (pin_rise || exit_by_write)
        begin
          state_next = ST_NORMAL;
          latched_mode_next = 3'h0;
        end
      end
      ST_SA:
      begin
        if (!pin_next)
          state_next = ST_RESET;
      end
      default:
        state_next = ST_RESET;
    endcase
  end

  // In the normal state, LED pins gate each enabled channel.
  wire [1:0] en_gated = hold_en_reg ? 2'b00 :
    (in_fso | in_sa) ? ctrl_reg.channel_enable :
    (state_reg == ST_NORMAL) ? (ctrl_reg.channel_enable & led_lvl_reg) :
    2'b00;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_RESET;
      ctrl_reg <= '0;
      latched_mode_reg <= 3'h0;
      init_cnt_reg <= 12'h000;
      hold_en_reg <= 1'b0;
      pin_lvl_reg <= 1'b0;
      led_lvl_reg <= 2'b00;
      buck_en_reg <= 2'b00;
      rst_out_reg <= 1'b1;
      sa_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      latched_mode_reg <= latched_mode_next;
      init_cnt_reg <= init_cnt_next;
      hold_en_reg <= hold_en_next;
      pin_lvl_reg <= pin_next;
      led_lvl_reg <= led_next;
      buck_en_reg <= en_gated;
      rst_out_reg <= state_next == ST_RESET;
      sa_reg <= state_next == ST_SA;
      blocked_reg <= blocked_w;
    end
  end

  // A flag event in the clearing cycle survives the clear.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fso_flag_reg <= 1'b0;
      serr_flag_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= RESET_WORD;
    end
    else
    begin
      fso_flag_reg <= fso_set | (fso_flag_reg & ~clr_flags);
      serr_flag_reg <= serial_frame_error |
        (serr_flag_reg & ~clr_flags);
      ack_reg <= bus_req & ~ack_reg;
      rdat_reg <= (bus_req & ~ack_reg) ? rd_word : RESET_WORD;
    end
  end

  assign wb_rsp = '{ack: ack_reg, dat: rdat_reg};
  assign ctrl_out = ctrl_reg;
  assign buck_enable = buck_en_reg;
  assign digital_reset = rst_out_reg;
  assign op_state = state_reg;
  assign failsafe_entered_flag = fso_flag_reg;
  assign serial_error_flag = serr_flag_reg;
  assign stand_alone_mode = sa_reg;
  assign serial_write_blocked = blocked_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_fso_entry;
    (state_reg != ST_FSO) ##1 (state_reg == ST_FSO);
  endsequence

  sequence seq_fso_exit;
    (state_reg == ST_FSO) ##1 (state_reg != ST_FSO);
  endsequence

  AST_INIT_DELAY: assert property (
    (state_reg == ST_INIT && state_next != ST_INIT &&
     state_next != ST_RESET) |-> init_cnt_reg == INIT_LAST)
    else $error("init left before its delay ran out");

  AST_FSO_FLAG: assert property (seq_fso_entry |-> fso_flag_reg)
    else $error("fail-safe flag not set on entry");

  AST_TRIM_COPY: assert property (
    seq_fso_entry |-> ctrl_reg.sense_trim_value ==
      $past(ctrl_reg.sense_range_value))
    else $error("trim not copied from range on entry");

  AST_LATCH_CLEAR: assert property (seq_fso_exit |->
    latched_mode_reg == 3'h0)
    else $error("latched mode not cleared on exit");

  AST_PIN_BLOCKED: assert property (
    (state_reg == ST_FSO) |=> state_reg != ST_RESET)
    else $error("reset pin acted while in fail-safe");

  AST_SA_RESET: assert property (
    (state_reg == ST_SA && pin_fall) |=> state_reg == ST_RESET ##1
      digital_reset)
    else $error("stand-alone pin fall did not reset");

  AST_HOLD_EN: assert property (hold_en_reg |=>
    buck_enable == 2'b00)
    else $error("enables driven while held off");

  AST_LED_IGNORED: assert property (
    ((state_reg == ST_FSO || state_reg == ST_SA) && !hold_en_reg) |=>
      buck_enable == $past(ctrl_reg.channel_enable))
    else $error("LED pins affect enables in fail-safe");

  AST_WRITE_BLOCK: assert property (
    (bus_done && wb_req.we && blocked_w && state_next == state_reg) |=>
      $stable(ctrl_reg))
    else $error("blocked write changed a register");

  AST_NO_CLEAR: assert property (
    (blocked_w && serr_flag_reg) |=> serr_flag_reg)
    else $error("blocked read cleared the error flag");

  AST_WRITE_EXIT: assert property (exit_by_write |=>
    state_reg == ST_NORMAL && latched_mode_reg == 3'h0)
    else $error("allowed mode write did not leave fail-safe");

endmodule : failsafe_mode_controller

// >>> tb/mcu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Microcontroller on the reset pin and the register bus
// ----------------------------------------------------------------------
module mcu_model (
  input wire logic clk,
  output fso_ctrl_pkg::wb_req_t wb_req,
  input wire fso_ctrl_pkg::wb_rsp_t wb_rsp,
  output logic reset_input_low
);
  import fso_ctrl_pkg::*;
  logic [31:0] rd_data = 32'h0;
  logic timed_out = 1'b0;
  initial
  begin
    wb_req = '0;
    reset_input_low = 1'b1;
  end
  // A fall asks for fail-safe entry and a rise for its exit.
  task automatic set_pin(input logic v);
    @(posedge clk);
    reset_input_low <= v;
  endtask : set_pin
  // The released bus shows inverted values so stale ones are never used.
  task automatic bus_cycle(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && n < 40);
    rd_data = wb_rsp.dat;
    timed_out = (n >= 40);
    wb_req <= '{1'b0, 1'b0, ~we, ~adr, 4'h0, ~dat};
    @(posedge clk);
  endtask : bus_cycle
endmodule : mcu_model

// >>> tb/test_failsafe_mode_controller.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Mode sequencing checks
// ----------------------------------------------------------------------
module test_failsafe_mode_controller;
  import fso_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] led_control_inputs;
  logic otp_lock_bit;
  otp_image_t otp_image;
  logic serial_frame_error;
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  logic reset_input_low;
  ctrl_regs_t ctrl_out;
  logic [1:0] buck_enable;
  logic digital_reset;
  op_state_t op_state;
  logic failsafe_entered_flag;
  logic serial_error_flag;
  logic stand_alone_mode;
  logic serial_write_blocked;
  logic [2:0] code;
  logic [31:0] v;
  int errors = 0;
  int checked = 0;
  int n;

  always #25 clk = ~clk;

  failsafe_mode_controller failsafe_mode_controller_inst (.clk(clk),
    .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .reset_input_low(reset_input_low),
    .led_control_inputs(led_control_inputs), .otp_lock_bit(otp_lock_bit),
    .otp_image(otp_image), .serial_frame_error(serial_frame_error),
    .ctrl_out(ctrl_out), .buck_enable(buck_enable),
    .digital_reset(digital_reset), .op_state(op_state),
    .failsafe_entered_flag(failsafe_entered_flag),
    .serial_error_flag(serial_error_flag),
    .stand_alone_mode(stand_alone_mode),
    .serial_write_blocked(serial_write_blocked));

  mcu_model mcu_model_inst (.clk(clk), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .reset_input_low(reset_input_low));

  task automatic check(input string what, input logic [47:0] exp,
    input logic [47:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Preloaded fields, enables left out because codes 100/101 hold them.
  function automatic logic [47:0] want(input otp_image_t o);
    return {o.threshold_upper, o.sense_range_low, o.off_time,
      o.failsafe_mode_select, o.thermal_auto_recover_enable,
      o.overcurrent_comparator_level};
  endfunction : want

  function automatic logic [47:0] seen(input ctrl_regs_t c);
    return {c.current_threshold_code[1][8:1],
      c.current_threshold_code[0][8:1], c.sense_range_select[1][1:0],
      c.sense_range_select[0][1:0], c.off_time, c.failsafe_mode_select,
      c.thermal_auto_recover_enable, c.overcurrent_comparator_level};
  endfunction : seen

  function automatic op_state_t after_fall(input logic [2:0] m);
    return (m < 3'h2 || m > 3'h5) ? ST_RESET : ST_FSO;
  endfunction : after_fall

  task automatic wait_state(input op_state_t s, input int limit);
    n = 0;
    while (op_state !== s && n < limit)
    begin
      @(posedge clk);
      n++;
    end
    check("op_state", s, op_state);
  endtask : wait_state

  task automatic bus(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    mcu_model_inst.bus_cycle(we, a, d);
    check("bus ack", 1'b0, mcu_model_inst.timed_out);
  endtask : bus

  task automatic pulse_error;
    @(posedge clk);
    serial_frame_error <= 1'b1;
    @(posedge clk);
    serial_frame_error <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_error

  task automatic boot(input logic [2:0] m, input op_state_t s);
    otp_image_t img;
    img = otp_image_t'(39'({$urandom, $urandom}));
    img.failsafe_mode_select = m;
    img.channel_enable = 2'b11;
    mcu_model_inst.set_pin(1'b1);
    rst <= 1'b1;
    otp_image <= img;
    repeat (12) @(posedge clk);
    check("reset held", 1'b1, digital_reset);
    rst <= 1'b0;
    wait_state(ST_INIT, 20);
    wait_state(s, 3100);
    check("init length", 1'b1, n > 2995 && n < 3005);
  endtask : boot

  initial
  begin
    void'($urandom(32'hd3e5));
    led_control_inputs <= 2'b00;
    otp_lock_bit <= 1'b1;
    otp_image <= '0;
    serial_frame_error <= 1'b0;
    for (int m = 0; m < 8; m++)
    begin
      code = 3'(m);
      boot(code, m > 5 ? ST_SA : ST_NORMAL);
      @(posedge clk);
      check("sa", m > 5, stand_alone_mode);
      check("blk0", m == 6, serial_write_blocked);
      v = (m == 0 || m == 2 || m == 3) ? 32'(m) << 4 : 32'h0;
      check("init regs", v != 0 || m == 0 ? 48'(v) : want(otp_image),
        seen(ctrl_out));
      mcu_model_inst.set_pin(1'b0);
      wait_state(after_fall(code), 10);
      repeat (2) @(posedge clk);
      check("fso", after_fall(code) == ST_FSO, failsafe_entered_flag);
      check("pin reset", after_fall(code) == ST_RESET, digital_reset);
      check("blk", m == 2 || m == 4, serial_write_blocked);
      if (after_fall(code) == ST_FSO)
        check("preload", want(otp_image), seen(ctrl_out));
    end
    boot(3'h0, ST_NORMAL);
    bus(1'b1, ADDR_CONTROL, 32'h3);
    v = $urandom;
    led_control_inputs <= v[1:0];
    repeat (8) @(posedge clk);
    check("leds follow", v[1:0], buck_enable);
    boot(3'h4, ST_NORMAL);
    led_control_inputs <= 2'b11;
    repeat (8) @(posedge clk);
    check("enables held", 2'b00, buck_enable);
    bus(1'b0, ADDR_THRESH, 32'h0);
    repeat (8) @(posedge clk);
    check("enables freed", 2'b11, buck_enable);
    boot(3'h2, ST_NORMAL);
    mcu_model_inst.set_pin(1'b0);
    wait_state(ST_FSO, 10);
    led_control_inputs <= 2'($urandom);
    repeat (8) @(posedge clk);
    check("leds ignored", 2'b11, buck_enable);
    bus(1'b1, ADDR_THRESH, 32'h01ff_01ff);
    check("write blocked", want(otp_image), seen(ctrl_out));
    pulse_error();
    check("error flag", 1'b1, serial_error_flag);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("latched mode", 3'h2, mcu_model_inst.rd_data[10:8]);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("flags kept", 2'b11, mcu_model_inst.rd_data[1:0]);
    check("pin blocked", ST_FSO, op_state);
    mcu_model_inst.set_pin(1'b1);
    wait_state(ST_NORMAL, 10);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("latch cleared", 3'h0, mcu_model_inst.rd_data[10:8]);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("flags cleared", 2'b00, mcu_model_inst.rd_data[1:0]);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, mcu_model_inst.rd_data);
    boot(3'h3, ST_NORMAL);
    v = $urandom & 32'h7f7f;
    bus(1'b1, ADDR_RANGE, v);
    mcu_model_inst.set_pin(1'b0);
    wait_state(ST_FSO, 10);
    repeat (2) @(posedge clk);
    check("trim", {v[14:8], v[6:0]}, {ctrl_out.sense_trim_value[1],
      ctrl_out.sense_trim_value[0]});
    bus(1'b1, ADDR_CONTROL, 32'h0);
    wait_state(ST_NORMAL, 10);
    otp_lock_bit <= 1'b0;
    boot(3'h2, ST_NORMAL);
    mcu_model_inst.set_pin(1'b0);
    wait_state(ST_RESET, 10);
    report_and_stop();
  end

  initial
  begin
    #3_000_000;
    errors++;
    report_and_stop();
  end
endmodule : test_failsafe_mode_controller
